// ---- src/adcif_host.sv ----
/*
 * Host controller for a clockless 10-bit sampling converter that sits on a
 * processor-style bus. Starts conversions, waits for the done interrupt
 * or the worst-case time, reads the result and queues it in a FIFO.
 * Assumes the converter pins are wired directly; the data bus is driven
 * only by the converter, so the host only samples it.
 */
// Notes on behaviour
// - Sample-start and chip select both low start a new conversion.
// - Read strobe and chip select both low put the result on the bus.
// - Channel select is latched at the falling edge of sample-start.
// - The converter sits on the bus like a memory or port, no clock.
`include "adcif_defs.svh"

module adcif_host
    import adcif_pkg::*;
#(
    parameter int NUM_INPUTS = 4,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // User request
    input  wire logic                       startReq,
    output logic                            startReady,
    input  wire logic [1:0]                 startChan,
    // User sample stream
    output logic                            sampleValid,
    input  wire logic                       sampleReady,
    output adcif_sample_s                   sampleData,
    // Converter pins
    output logic                            chipSel_n,
    output logic                            sampleStart_n,
    output logic                            readStrobe_n,
    output logic                            chan_sel_lo,
    output logic                            chan_sel_hi,
    input  wire logic                       convDone_n,
    input  wire logic [`ADCIF_RESULT_W-1:0] result_bus,
    // Status
    output logic                            busy
);
    localparam logic [4:0] CONV_CYC   = 5'(`ADCIF_CONV_CYC);
    localparam logic [4:0] STROBE_CYC = 5'(`ADCIF_STROBE_CYC);

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    logic                       doneMeta_reg, doneSync_reg;
    logic [`ADCIF_RESULT_W-1:0] busMeta_reg, busSync_reg;

    // Two stages before any logic reads the pins
    always_ff @(posedge clk) begin
        if (srst) begin
            doneMeta_reg <= 1'b1;
            doneSync_reg <= 1'b1;
            busMeta_reg  <= '0;
            busSync_reg  <= '0;
        end else begin
            doneMeta_reg <= convDone_n;
            doneSync_reg <= doneMeta_reg;
            busMeta_reg  <= result_bus;
            busSync_reg  <= busMeta_reg;
        end
    end

    // Channel lines allowed by the variant
    function automatic logic [1:0] chanMask(input logic [1:0] c);
        if (NUM_INPUTS >= 4) begin
            chanMask = c;
        end else if (NUM_INPUTS == 2) begin
            chanMask = {1'b0, c[0]};
        end else begin
            chanMask = 2'b00;
        end
    endfunction : chanMask

    // ======================================================================
    // Sequencer
    // ======================================================================
    adcif_state_e  state_reg, state_next;
    logic [4:0]    timer_reg, timer_next;
    logic [1:0]    chan_reg, chan_next;
    logic          cs_reg, cs_next, sh_reg, sh_next, rd_reg, rd_next;
    logic          tout_reg, tout_next;
    adcif_sample_s word_reg, word_next;
    logic          pushValid, pushReady;

    assign pushValid  = (state_reg == ST_PUSH);
    assign startReady = (state_reg == ST_IDLE);

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        chan_next  = chan_reg;
        cs_next    = cs_reg;
        sh_next    = sh_reg;
        rd_next    = rd_reg;
        tout_next  = tout_reg;
        word_next  = word_reg;
        case (state_reg)
            ST_IDLE: begin
                if (startReq) begin
                    // Channel set up one strobe width before the falling edge
                    chan_next  = chanMask(startChan);
                    cs_next    = 1'b1;
                    timer_next = STROBE_CYC;
                    state_next = ST_START;
                end
            end
            ST_START: begin
                if (timer_reg == 5'h0_0 && !sh_reg) begin
                    sh_next    = 1'b1;
                    timer_next = STROBE_CYC;
                end else if (timer_reg == 5'h0_0) begin
                    sh_next    = 1'b0;
                    timer_next = CONV_CYC;
                    tout_next  = 1'b0;
                    state_next = ST_WAIT;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            ST_WAIT: begin
                // Done line or worst-case time, whichever first
                if (!doneSync_reg) begin
                    rd_next    = 1'b1;
                    timer_next = STROBE_CYC;
                    state_next = ST_READ;
                end else if (timer_reg == 5'h0_0) begin
                    tout_next  = 1'b1;
                    rd_next    = 1'b1;
                    timer_next = STROBE_CYC;
                    state_next = ST_READ;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            ST_READ: begin
                // Bus has passed two sync stages before capture
                if (timer_reg == 5'h0_0) begin
                    word_next.code     = busSync_reg;
                    word_next.chan     = chan_reg;
                    word_next.timedOut = tout_reg;
                    rd_next    = 1'b0;
                    timer_next = STROBE_CYC;
                    state_next = ST_RELS;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            ST_RELS: begin
                // Let the done line recover before the next start
                if (timer_reg == 5'h0_0) begin
                    cs_next    = 1'b0;
                    state_next = ST_PUSH;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            ST_PUSH: begin
                // Stalls here while the FIFO is full
                if (pushReady) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            timer_reg <= 5'h0_0;
            chan_reg  <= 2'h0;
            cs_reg    <= 1'b0;
            sh_reg    <= 1'b0;
            rd_reg    <= 1'b0;
            tout_reg  <= 1'b0;
            word_reg  <= '0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            chan_reg  <= chan_next;
            cs_reg    <= cs_next;
            sh_reg    <= sh_next;
            rd_reg    <= rd_next;
            tout_reg  <= tout_next;
            word_reg  <= word_next;
        end
    end

    // Pin drive from flops, all strobes idle high
    assign chipSel_n     = ~cs_reg;
    assign sampleStart_n = ~sh_reg;
    assign readStrobe_n  = ~rd_reg;
    assign chan_sel_lo   = chan_reg[0];
    assign chan_sel_hi   = chan_reg[1];
    assign busy          = (state_reg != ST_IDLE);

    // ======================================================================
    // Sample queue
    // ======================================================================
    adcif_fifo #(
        .WIDTH ($bits(adcif_sample_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .srst     (srst),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (word_reg),
        .outValid (sampleValid),
        .outReady (sampleReady),
        .outData  (sampleData)
    );

endmodule : adcif_host

// ---- src/adcif_defs.svh ----
/*
 * Timing counts and widths for the converter host controller.
 * Assumes a 20 MHz system clock (50 ns period).
 */
`ifndef ADCIF_DEFS_SVH
`define ADCIF_DEFS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define ADCIF_CLK_PERIOD_NS   50
`define ADCIF_CONV_MAX_NS     900
// Longest-wait timeout: whole cycles covering the maximum conversion time
`define ADCIF_CONV_CYC \
    ((`ADCIF_CONV_MAX_NS + `ADCIF_CLK_PERIOD_NS - 1) / `ADCIF_CLK_PERIOD_NS)
`define ADCIF_STROBE_CYC      2
`define ADCIF_RESULT_W        10
`define ADCIF_CODE_MAX        10'h3FF

`endif

// ---- src/adcif_pkg.sv ----
/*
 * Types shared by the converter host controller.
 * Assumes adcif_defs.svh is on the include path.
 */
`include "adcif_defs.svh"

package adcif_pkg;

    // ======================================================================
    // Sample word handed to the user side
    // ======================================================================
    typedef struct packed {
        logic [1:0]                   chan;
        logic                         timedOut;
        logic [`ADCIF_RESULT_W-1:0]   code;
    } adcif_sample_s;

    // ======================================================================
    // Sequencer states
    // ======================================================================
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b00_0001,
        ST_START = 6'b00_0010,
        ST_WAIT  = 6'b00_0100,
        ST_READ  = 6'b00_1000,
        ST_RELS  = 6'b01_0000,
        ST_PUSH  = 6'b10_0000
    } adcif_state_e;

endpackage : adcif_pkg

// ---- src/adcif_fifo.sv ----
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes a single clock and synchronous active-high reset.
 */
module adcif_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             srst,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
    logic [AW:0]      count_reg, count_next;
    logic             push, pop;

    // Honest full and empty from the occupancy count
    assign inReady  = (count_reg != (AW+1)'(DEPTH));
    assign outValid = (count_reg != '0);
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;
    assign outData  = mem[rdPtr_reg];

    // Pointer and count update
    always_comb begin
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        count_next = count_reg;
        if (push) begin
            wrPtr_next = (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
        end
        if (pop) begin
            rdPtr_next = (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // Registers only
    always_ff @(posedge clk) begin
        if (srst) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
        end else begin
            wrPtr_reg <= wrPtr_next;
            rdPtr_reg <= rdPtr_next;
            count_reg <= count_next;
        end
    end

    // Storage array, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

endmodule : adcif_fifo

// ---- bench/adcif_host_asserts.sv ----
/* Checker for the converter host pins and sample stream.
   Assumes a bind from the bench top onto adcif_host. */
module adcif_host_asserts
    import adcif_pkg::*;
(
    // Clock and reset
    input wire logic          clk,
    input wire logic          srst,
    // User side
    input wire logic          startReq,
    input wire logic          startReady,
    input wire logic          sampleValid,
    input wire logic          sampleReady,
    input wire adcif_sample_s sampleData,
    input wire logic          busy,
    // Converter pins
    input wire logic          chipSel_n,
    input wire logic          sampleStart_n,
    input wire logic          readStrobe_n,
    input wire logic          chan_sel_lo,
    input wire logic          chan_sel_hi
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ======================================================================
    // Pin discipline
    // ======================================================================
    start_cs_a: assert property (!sampleStart_n |-> !chipSel_n)
        else $error("sample start outside select");
    read_cs_a: assert property (!readStrobe_n |-> !chipSel_n)
        else $error("read outside select");
    no_overlap_a: assert property (!sampleStart_n |-> readStrobe_n)
        else $error("read during sample start");
    start_pulse_a: assert property ($fell(sampleStart_n) |->
        !sampleStart_n[*3] ##1 sampleStart_n)
        else $error("sample start width wrong");
    read_pulse_a: assert property ($fell(readStrobe_n) |->
        !readStrobe_n[*3] ##1 readStrobe_n)
        else $error("read width wrong");
    conv_bound_a: assert property ($rose(sampleStart_n) |->
        ##[1:19] $fell(readStrobe_n))
        else $error("no read after conversion time");
    wait_done_a: assert property ($rose(sampleStart_n) |->
        readStrobe_n[*2])
        else $error("read too soon after start");
    chan_hold_a: assert property (!chipSel_n && $past(!chipSel_n) |->
        $stable({chan_sel_hi, chan_sel_lo}))
        else $error("channel lines moved in access");
    take_start_a: assert property (startReq && startReady |=>
        busy && !chipSel_n)
        else $error("request not taken");
    // Stream side
    hold_word_a: assert property (sampleValid && !sampleReady |=>
        sampleValid && $stable(sampleData))
        else $error("word lost while stalled");
endmodule : adcif_host_asserts

// ---- bench/adcif_conv_model.sv ----
/* Behavioural converter seen from its pins.
   Assumes the bench clock only paces the model. */
module adcif_conv_model (
    // Clock
    input  wire logic       clk,
    // Pins from the host
    input  wire logic       chipSel_n,
    input  wire logic       sampleStart_n,
    input  wire logic       readStrobe_n,
    input  wire logic       chan_sel_lo,
    input  wire logic       chan_sel_hi,
    output logic            convDone_n,
    output logic [9:0]      result_bus,
    // Bench control
    input  wire logic [9:0] convCode,
    input  wire logic [7:0] convDelay,
    output logic [1:0]      chanSeen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] outReg = 10'h0;
    logic       ssPrev = 1'b1;
    logic       rdPrev = 1'b1;
    logic [7:0] cnt    = 8'h0;
    initial convDone_n = 1'b1;
    initial chanSeen = 2'h0;
    // Start, finish and release; start wins over a pending finish
    always @(posedge clk) begin
        ssPrev <= sampleStart_n;
        rdPrev <= readStrobe_n;
        if (!chipSel_n && ssPrev && !sampleStart_n) begin
            chanSeen   <= {chan_sel_hi, chan_sel_lo};
            cnt        <= convDelay;
            convDone_n <= 1'b1;
        end else if (cnt > 8'h1) begin
            cnt <= cnt - 8'h1;
        end else if (cnt == 8'h1) begin
            cnt        <= 8'h0;
            outReg     <= convCode;
            convDone_n <= 1'b0;
        end
        if (!chipSel_n && !rdPrev && readStrobe_n) convDone_n <= 1'b1;
    end
    // Released bus shows the inverse so stale data cannot pass
    assign result_bus = (!chipSel_n && !readStrobe_n) ? outReg
                                                      : ~outReg;
endmodule : adcif_conv_model

// ---- bench/testbench.sv ----
/* Self-checking bench for the converter host controller.
   Assumes the checker and converter model are compiled first. */
module testbench
    import adcif_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, startReq, startReady, sampleValid, sampleReady, busy;
    logic chipSel_n, sampleStart_n, readStrobe_n, chan_sel_lo, chan_sel_hi;
    logic convDone_n;
    logic [1:0] startChan, chanSeen;
    logic [9:0] result_bus, convCode;
    logic [7:0] convDelay;
    adcif_sample_s sampleData;
    int errorCnt, checksDone;
    adcif_host i_dut (.clk, .srst, .startReq, .startReady, .startChan,
        .sampleValid, .sampleReady, .sampleData, .chipSel_n, .sampleStart_n,
        .readStrobe_n, .chan_sel_lo, .chan_sel_hi, .convDone_n, .result_bus,
        .busy);
    adcif_conv_model i_conv (.clk, .chipSel_n, .sampleStart_n, .readStrobe_n,
        .chan_sel_lo, .chan_sel_hi, .convDone_n, .result_bus, .convCode,
        .convDelay, .chanSeen);
    // Two-input variant shares clock, reset, channel, pop and model setup
    logic startReq2, startReady2, sampleValid2, busy2, convDone2_n;
    logic chipSel2_n, sampleStart2_n, readStrobe2_n, chanLo2, chanHi2;
    logic [1:0] chanSeen2;
    logic [9:0] result2;
    adcif_sample_s sampleData2;
    adcif_host #(.NUM_INPUTS(2), .FIFO_DEPTH(8)) i_dut2 (.clk, .srst,
        .startReq(startReq2), .startReady(startReady2), .startChan,
        .sampleValid(sampleValid2), .sampleReady, .sampleData(sampleData2),
        .chipSel_n(chipSel2_n), .sampleStart_n(sampleStart2_n),
        .readStrobe_n(readStrobe2_n), .chan_sel_lo(chanLo2),
        .chan_sel_hi(chanHi2), .convDone_n(convDone2_n),
        .result_bus(result2), .busy(busy2));
    adcif_conv_model i_conv2 (.clk, .chipSel_n(chipSel2_n),
        .sampleStart_n(sampleStart2_n), .readStrobe_n(readStrobe2_n),
        .chan_sel_lo(chanLo2), .chan_sel_hi(chanHi2),
        .convDone_n(convDone2_n), .result_bus(result2), .convCode,
        .convDelay, .chanSeen(chanSeen2));
    // ======================================================================
    // Shared tasks
    // ======================================================================
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errorCnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic endOfTest();
        $display("Checks %0d errors %0d", checksDone, errorCnt);
        if (errorCnt == 0 && checksDone > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : endOfTest
    // Request pulsed once so a held level cannot start twice
    task automatic startConv(input logic [1:0] ch, input logic [9:0] code,
                             input logic [7:0] dly);
        int n = 0;
        do begin @(negedge clk); n++; end
        while (startReady !== 1'b1 && n < 400);
        if (startReady !== 1'b1) begin errorCnt++; endOfTest(); end
        @(posedge clk);
        startReq  <= 1'b1;
        startChan <= ch;
        convCode  <= code;
        convDelay <= dly;
        @(posedge clk);
        startReq  <= 1'b0;
    endtask : startConv
    task automatic popWord(input logic [12:0] exp);
        int n = 0;
        do begin @(negedge clk); n++; end
        while (sampleValid !== 1'b1 && n < 400);
        if (sampleValid !== 1'b1) begin errorCnt++; endOfTest(); end
        check(16'(sampleData), 16'(exp));
        @(posedge clk);
        sampleReady <= 1'b1;
        @(posedge clk);
        sampleReady <= 1'b0;
    endtask : popWord
    // ======================================================================
    // Scenarios
    // ======================================================================
    task automatic tChannels();
        logic [9:0] codes [4] = '{10'h0, 10'h3FF, 10'h155, 10'h2AA};
        logic [7:0] dlys [4] = '{8'h1, 8'hC, 8'h3, 8'hF};
        for (int i = 0; i < 4; i++) begin
            startConv(2'(i), codes[i], dlys[i]);
            popWord({2'(i), 1'b0, codes[i]});
            check(16'(chanSeen), 16'(i));
        end
    endtask : tChannels
    // Converter too slow: host reads after the worst-case time
    task automatic tTimeout();
        startConv(2'h1, 10'h123, 8'h3C);
        popWord({2'h1, 1'b1, 10'h2AA});
    endtask : tTimeout
    // Fill the queue past its depth while the reader stalls
    task automatic tFill();
        for (int i = 0; i < 9; i++) startConv(2'(i), 10'(16 + i), 8'h2);
        repeat (60) @(negedge clk);
        check(16'({busy, chipSel_n, startReady}), 16'h6);
        @(posedge clk);
        startReq <= 1'b1;
        @(posedge clk);
        startReq <= 1'b0;
        for (int i = 0; i < 9; i++) popWord({2'(i), 1'b0, 10'(16 + i)});
        repeat (60) @(negedge clk);
        check(16'({sampleValid, busy}), 16'h0);
    endtask : tFill
    // Two-input variant: the high channel line must stay low
    task automatic tTwoInput();
        int n = 0;
        @(posedge clk);
        startReq2 <= 1'b1;
        startChan <= 2'h3;
        convCode  <= 10'h2C5;
        convDelay <= 8'h2;
        @(posedge clk);
        startReq2 <= 1'b0;
        do begin @(negedge clk); n++; end
        while (sampleValid2 !== 1'b1 && n < 400);
        if (sampleValid2 !== 1'b1) begin errorCnt++; endOfTest(); end
        check(16'(sampleData2), 16'({2'h1, 1'b0, 10'h2C5}));
        check(16'(chanSeen2), 16'h1);
        @(posedge clk);
        sampleReady <= 1'b1;
        @(posedge clk);
        sampleReady <= 1'b0;
    endtask : tTwoInput
    // ======================================================================
    // Clock and main sequence
    // ======================================================================
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        srst = 1'b1;
        startReq = 1'b0;
        startReq2 = 1'b0;
        startChan = 2'h0;
        sampleReady = 1'b0;
        convCode = 10'h0;
        convDelay = 8'h1;
        errorCnt = 0;
        checksDone = 0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        check(16'({chipSel_n, sampleStart_n, readStrobe_n, busy, startReady,
            sampleValid}), 16'h3A);
        @(posedge clk);
        srst <= 1'b0;
        tChannels();
        tTimeout();
        tFill();
        tTwoInput();
        endOfTest();
    end
endmodule : testbench
bind adcif_host adcif_host_asserts i_chk (.clk, .srst, .startReq, .startReady,
    .sampleValid, .sampleReady, .sampleData, .busy, .chipSel_n,
    .sampleStart_n, .readStrobe_n, .chan_sel_lo, .chan_sel_hi);
